/* File: logic/device_control_pkg.sv */
package device_control_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int          REG_ADDR_W          = 8;
  localparam int          REG_DATA_W          = 24;
  localparam logic [7:0]  DEVICE_CONTROL_ADDR = 8'h00;
  localparam logic [23:0] DEVICE_CONTROL_RST  = 24'h000000;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CAPTURE_TRIGGER_BIT   = 23;
  localparam int FORCE_TARGET_BIT      = 22;
  localparam int BYPASS_BIT            = 21;
  localparam int CONTINUOUS_ACCESS_BIT = 6;
  localparam int SOFT_RESET_BIT        = 0;
  // writable bits; the reserved fields are held at zero
  localparam logic [23:0] WRITABLE_MASK = 24'hE00041;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int SOFT_RESET_CYCLES = 4;
endpackage

/* File: logic/soft_reset_pulse.sv */
`timescale 1ns/1ps
module soft_reset_pulse
  import device_control_pkg::*;
#(
  parameter int CYCLES = SOFT_RESET_CYCLES
) (
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic start_in,
  output logic      reset_active_out
);
  typedef struct packed {
    logic [7:0] count;
  } pulse_state_t;

  pulse_state_t state;
  pulse_state_t next_state;

  always_comb begin
    next_state = state;
    if (start_in) begin
      next_state.count = 8'(CYCLES);
    end else if (state.count != 8'h00) begin
      next_state.count = state.count - 8'h01;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign reset_active_out = (state.count != 8'h00);
endmodule

/* File: logic/device_control_register.sv */
`timescale 1ns/1ps
module device_control_register
  import device_control_pkg::*;
(
  input  wire logic                  clk_in,
  input  wire logic                  nrst_in,
  input  wire logic                  wr_en_in,
  input  wire logic                  rd_en_in,
  input  wire logic [REG_ADDR_W-1:0] addr_in,
  input  wire logic [REG_DATA_W-1:0] wr_data_in,
  output logic      [REG_DATA_W-1:0] rd_data_out,
  output logic                       rd_valid_out,
  input  wire logic                  capture_done_in,
  output logic                       capture_start_out,
  output logic                       capture_busy_out,
  output logic                       force_target_access_out,
  output logic                       aux_bypass_out,
  output logic                       continuous_access_enable_out,
  output logic                       device_reset_out
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [REG_DATA_W-1:0] control;
    logic [REG_DATA_W-1:0] rd_data;
    logic                  rd_valid;
    logic                  start;
  } ctrl_state_t;

  ctrl_state_t state;
  ctrl_state_t next_state;
  logic        soft_reset_active;
  logic        hit;
  logic        soft_reset_write;

  assign hit              = (addr_in == DEVICE_CONTROL_ADDR);
  assign soft_reset_write = wr_en_in && hit && wr_data_in[SOFT_RESET_BIT];

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_state          = state;
    next_state.rd_valid = 1'b0;
    next_state.start    = 1'b0;
    if (rd_en_in) begin
      next_state.rd_valid = 1'b1;
      next_state.rd_data  = hit ? (state.control & WRITABLE_MASK) : '0;
    end
    // completion clears the trigger; a new write in the same cycle re-arms it
    if (capture_done_in) begin
      next_state.control[CAPTURE_TRIGGER_BIT] = 1'b0;
    end
    if (wr_en_in && hit) begin
      next_state.control = wr_data_in & WRITABLE_MASK;
      if (!wr_data_in[CAPTURE_TRIGGER_BIT] && state.control[CAPTURE_TRIGGER_BIT] && !capture_done_in) begin
        // a capture in flight cannot be cancelled by writing zero
        next_state.control[CAPTURE_TRIGGER_BIT] = 1'b1;
      end
      if (wr_data_in[CAPTURE_TRIGGER_BIT]) begin
        next_state.start = 1'b1;
      end
    end
    if (soft_reset_write || soft_reset_active) begin
      next_state.control = DEVICE_CONTROL_RST;
      next_state.start   = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      state <= '{control: DEVICE_CONTROL_RST, rd_data: '0, rd_valid: 1'b0, start: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // soft reset stretcher
  // ---------------------------------------------------------------
  soft_reset_pulse #(
    .CYCLES (SOFT_RESET_CYCLES)
  ) u_soft_reset (
    .clk_in           (clk_in),
    .nrst_in          (nrst_in),
    .start_in         (soft_reset_write),
    .reset_active_out (soft_reset_active)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign rd_data_out                  = state.rd_data;
  assign rd_valid_out                 = state.rd_valid;
  assign capture_start_out            = state.start;
  assign capture_busy_out             = state.control[CAPTURE_TRIGGER_BIT];
  assign force_target_access_out      = state.control[FORCE_TARGET_BIT];
  assign aux_bypass_out               = state.control[BYPASS_BIT];
  assign continuous_access_enable_out = state.control[CONTINUOUS_ACCESS_BIT];
  assign device_reset_out             = soft_reset_active;
endmodule

/* File: test/capture_engine_model.sv */
`timescale 1ns/1ps
module capture_engine_model #(
  parameter int DLY = 5
) (
  input  wire logic clk_in,
  input  wire logic start_in,
  output logic      done_out
);
  int n = 0;
  initial done_out = 1'b0;
  // one capture at a time; a new start restarts the countdown
  always @(posedge clk_in) begin
    done_out <= (n == 1);
    n <= start_in ? DLY : (n > 0 ? n - 1 : 0);
  end
endmodule

/* File: test/device_control_register_props.sv */
`timescale 1ns/1ps
module device_control_register_props
  import device_control_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        nrst_in,
  input wire logic        wr_en_in,
  input wire logic        rd_en_in,
  input wire logic        capture_done_in,
  input wire logic        rd_valid_out,
  input wire logic [7:0]  addr_in,
  input wire logic [23:0] wr_data_in,
  input wire logic [23:0] rd_data_out,
  input wire logic        capture_start_out,
  input wire logic        capture_busy_out,
  input wire logic        force_target_access_out,
  input wire logic        device_reset_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  logic wr0;
  // writes while the soft reset stretch runs are dropped
  assign wr0 = wr_en_in && addr_in == 8'h00 && !device_reset_out;
  a_capture_start: assert property (wr0 && wr_data_in[23] && !wr_data_in[0] |=> capture_start_out && capture_busy_out)
    else $error("capture not started");
  a_start_single: assert property (capture_start_out |=> !capture_start_out)
    else $error("start pulse too long");
  a_busy_clear: assert property (capture_done_in && !(wr0 && wr_data_in[23]) |=> !capture_busy_out)
    else $error("busy not cleared");
  a_busy_hold: assert property (capture_busy_out && !capture_done_in && !(wr0 && wr_data_in[0]) |=> capture_busy_out)
    else $error("busy dropped early");
  a_force_follow: assert property (wr0 && !wr_data_in[0] |=> force_target_access_out == $past(wr_data_in[22]))
    else $error("force bit wrong");
  a_soft_reset: assert property (wr0 && wr_data_in[0] |=> device_reset_out [*4] ##1 !device_reset_out)
    else $error("soft reset length wrong");
  a_reset_clears: assert property (device_reset_out |-> !capture_busy_out && !force_target_access_out)
    else $error("controls kept in soft reset");
  a_read_clean: assert property (rd_en_in |=> rd_valid_out && (rd_data_out & ~WRITABLE_MASK) == 24'h000000)
    else $error("reserved bits read set");
  a_unmapped_zero: assert property (rd_en_in && addr_in != 8'h00 |=> rd_data_out == 24'h000000)
    else $error("unmapped read not zero");
  a_reset_zero: assert property ($rose(nrst_in) |-> !capture_busy_out && !force_target_access_out)
    else $error("outputs set after reset");
endmodule
bind device_control_register device_control_register_props chk (.*);

/* File: test/tb_device_control_register.sv */
`timescale 1ns/1ps
module tb_device_control_register;
  import device_control_pkg::*;
  logic        clk_in = 0, nrst_in = 0, wr_en_in = 0, rd_en_in = 0, done, rd_valid_out, start, busy, frc, byp, cont, dres;
  logic [7:0]  addr_in = 8'h00;
  logic [23:0] wr_data_in = 24'h000000, rd_data_out, d, exp_q[$];
  logic [31:0] lf = 32'hD500;
  int          err_total = 0, compares = 0, cyc = 0;
  device_control_register dut (.clk_in, .nrst_in, .wr_en_in, .rd_en_in, .addr_in, .wr_data_in, .rd_data_out,
    .rd_valid_out, .capture_done_in(done), .capture_start_out(start), .capture_busy_out(busy),
    .force_target_access_out(frc), .aux_bypass_out(byp), .continuous_access_enable_out(cont), .device_reset_out(dres));
  capture_engine_model eng (.clk_in, .start_in(start), .done_out(done));
  initial forever #5 clk_in = ~clk_in;
  task automatic chk(string n, logic [23:0] e, logic [23:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  // one strobe per call; a read queues its expected word
  task automatic acc(logic w, logic [7:0] a, logic [23:0] v);
    @(negedge clk_in);
    {wr_en_in, rd_en_in, addr_in, wr_data_in} = {w, !w, a, v};
    if (!w) exp_q.push_back(v);
    @(negedge clk_in);
    {wr_en_in, rd_en_in} = 2'b00;
  endtask
  task automatic conclude;
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(negedge clk_in) if (rd_valid_out === 1'b1) chk("rd_data", exp_q.pop_front(), rd_data_out);
  always @(posedge clk_in) begin
    cyc++;
    if (cyc > 3000) begin
      err_total++;
      conclude;
    end
  end
  initial begin
    repeat (10) @(negedge clk_in);
    nrst_in = 1;
    acc(0, 8'h00, 24'h000000);
    for (int i = 0; i < 8; i++) begin
      lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
      d = lf[23:0] & 24'h600040;
      acc(1, 8'h00, d);
      acc(1, 8'h5A, 24'hFFFFFF);
      acc(0, 8'h00, d);
      chk("ctl", 24'({1'b0, d[22], d[21], d[6], 1'b0}), 24'({busy, frc, byp, cont, dres}));
    end
    acc(0, 8'h33, 24'h000000);
    acc(1, 8'h00, 24'h800040);
    acc(0, 8'h00, 24'h800040);
    repeat (8) @(negedge clk_in);
    acc(0, 8'h00, 24'h000040);
    // host writes force access together with soft reset; the soft reset clears force access
    acc(1, 8'h00, 24'h400001);
    chk("ctl", 24'h000001, 24'({busy, frc, byp, cont, dres}));
    repeat (5) @(negedge clk_in);
    acc(0, 8'h00, 24'h000000);
    repeat (3) @(negedge clk_in);
    conclude;
  end
endmodule
